// >>> hdl/frame_sync_pkg.sv
// package: register map, field layouts and enumerations of the frame sync block
package frame_sync_pkg;
  // register byte offsets on the slave bus
  localparam logic [5:0] OFS_RX_CLK_MODE  = 6'h00;
  localparam logic [5:0] OFS_RX_FRM_MODE  = 6'h04;
  localparam logic [5:0] OFS_TX_CLK_MODE  = 6'h08;
  localparam logic [5:0] OFS_TX_FRM_MODE  = 6'h0C;
  localparam logic [5:0] OFS_RX_SYNC_HOLD = 6'h10;
  localparam logic [5:0] OFS_TX_SYNC_HOLD = 6'h14;
  localparam logic [5:0] OFS_IRQ_STATUS   = 6'h18;
  localparam logic [5:0] OFS_IRQ_ENABLE   = 6'h1C;
  localparam logic [5:0] OFS_IRQ_CLEAR    = 6'h20;
  localparam logic [5:0] OFS_TX_DATA      = 6'h24;

  // direction indices and status bit positions
  localparam int DIR_RX         = 0;
  localparam int DIR_TX         = 1;
  localparam int ST_RX_SYNC     = 0;
  localparam int ST_TX_SYNC     = 1;
  localparam int ST_RX_FRAME    = 2;
  localparam int ST_TX_FRAME    = 3;
  localparam int NUM_EVENTS     = 4;
  localparam int SYNC_DATA_MAX  = 16;
  localparam logic [7:0] SYNC_BITS_LAST = 8'h0F;

  // reset values
  localparam logic [16:0] CFG_RESET  = 17'h0_0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // frame pin waveform selection
  typedef enum logic [2:0] {
    SEL_INPUT     = 3'b000,
    SEL_NEG_PULSE = 3'b001,
    SEL_POS_PULSE = 3'b010,
    SEL_LOW_DATA  = 3'b011,
    SEL_HIGH_DATA = 3'b100,
    SEL_TOGGLE    = 3'b101
  } sync_sel_t;

  // frame phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SYNC = 2'b01,
    PH_DATA = 2'b10
  } phase_t;

  // clock mode register layout, bits 16..0
  typedef struct packed {
    logic       clk_out_en;  // drive the clock pin
    logic [7:0] period;      // frame every 2*(period+1) bits, 0 = none
    logic [7:0] bit_div;     // bit time = 2*(bit_div+1) clocks
  } clk_cfg_t;

  // frame mode register layout, bits 16..0
  typedef struct packed {
    logic       sync_data_enable; // tx only: send sync tag
    sync_sel_t  sync_out_select;
    logic [4:0] data_len;         // data phase bits minus one
    logic [7:0] sync_length;      // sync pulse bits minus one
  } frm_cfg_t;
endpackage

// >>> hdl/sync_serial_frame_sync.sv
// top: frame sync generation, sync tag transfer and interrupt of the serial ctrl
//
// Function
// - each frame pin is driven with the waveform picked by sync_out_select
// - a sync pulse lasts sync_length plus one bit times, 1 to 256
// - frames repeat at a period set by the clock mode period field
// - during sync, rx data is sampled and tx sync holding is shifted out
// - sync tag bit count follows sync_length, capped at sixteen bits
// - received sync tag passes through the rx shifter into rx sync holding
// - tx sync tag is sent only while sync_data_enable is set
// - data phase loads normal tx data after the tag, data taking priority
// - interrupt output is high while any enabled status bit is pending
// - a readable status register tells which source is pending
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
module sync_serial_frame_sync
  import frame_sync_pkg::*;
(
  input  wire logic        REF_CLK_IN,       // peripheral clock, 20 MHz
  input  wire logic        RST_IN,           // async reset, active high
  input  wire logic [5:0]  AVS_ADDRESS_IN,   // byte address
  input  wire logic        AVS_READ_IN,      // read request
  input  wire logic        AVS_WRITE_IN,     // write request
  input  wire logic [31:0] AVS_WRITEDATA_IN, // write data
  output logic      [31:0] AVS_READDATA_OUT, // read data
  output logic             AVS_WAITREQUEST_OUT, // stall
  output logic             IRQ_OUT,          // level interrupt
  input  wire logic        RX_DATA_IN,       // receive data pin
  output logic             TX_DATA_OUT,      // transmit data pin
  input  wire logic        RX_CLOCK_PIN_IN,  // rx clock pin level
  output logic             RX_CLOCK_PIN_OUT, // rx clock pin drive
  output logic             RX_CLOCK_PIN_OE_OUT, // rx clock pin enable
  input  wire logic        TX_CLOCK_PIN_IN,  // tx clock pin level
  output logic             TX_CLOCK_PIN_OUT, // tx clock pin drive
  output logic             TX_CLOCK_PIN_OE_OUT, // tx clock pin enable
  input  wire logic        RX_FRAME_PIN_IN,  // rx frame pin level
  output logic             RX_FRAME_PIN_OUT, // rx frame pin drive
  output logic             RX_FRAME_PIN_OE_OUT, // rx frame pin enable
  input  wire logic        TX_FRAME_PIN_IN,  // tx frame pin level
  output logic             TX_FRAME_PIN_OUT, // tx frame pin drive
  output logic             TX_FRAME_PIN_OE_OUT  // tx frame pin enable
);

  clk_cfg_t                  clk_cfg [2];
  frm_cfg_t                  frm_cfg [2];
  logic [15:0]               rx_sync_hold;
  logic [15:0]               tx_sync_hold;
  logic [15:0]               tx_data;
  logic [NUM_EVENTS-1:0]     irq_status;
  logic [NUM_EVENTS-1:0]     irq_enable;
  logic [NUM_EVENTS-1:0]     irq_events;
  logic                      bus_ack;
  logic                      bus_req;
  logic                      wr_take;
  logic                      clr_take;
  logic [31:0]               next_rdata;
  logic [1:0]                bit_tick;
  logic [1:0]                clk_lvl;
  logic [1:0]                frame_start;
  logic [1:0]                sync_end;
  logic [1:0]                data_start;
  logic [1:0]                frame_out;
  phase_t                    phase [2];
  logic [7:0]                bit_cnt [2];
  logic [15:0]               rx_shift;
  logic [15:0]               tx_shift;

  // decode of a bus address against one register offset
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  // one wait cycle per access keeps read data a registered value
  assign bus_req             = AVS_READ_IN | AVS_WRITE_IN;
  assign AVS_WAITREQUEST_OUT = bus_req & ~bus_ack;
  assign wr_take             = AVS_WRITE_IN & bus_ack;
  assign clr_take            = wr_take & hit(AVS_ADDRESS_IN, OFS_IRQ_CLEAR);

  // ack rises one cycle after the request and drops at the answer edge
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  // read mux; unmapped and write-only offsets read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (AVS_ADDRESS_IN)
      OFS_RX_CLK_MODE:  next_rdata[16:0]  = clk_cfg[DIR_RX];
      OFS_RX_FRM_MODE:  next_rdata[16:0]  = frm_cfg[DIR_RX];
      OFS_TX_CLK_MODE:  next_rdata[16:0]  = clk_cfg[DIR_TX];
      OFS_TX_FRM_MODE:  next_rdata[16:0]  = frm_cfg[DIR_TX];
      OFS_RX_SYNC_HOLD: next_rdata[15:0]  = rx_sync_hold;
      OFS_TX_SYNC_HOLD: next_rdata[15:0]  = tx_sync_hold;
      OFS_IRQ_STATUS:   next_rdata[NUM_EVENTS-1:0] = irq_status;
      OFS_IRQ_ENABLE:   next_rdata[NUM_EVENTS-1:0] = irq_enable;
      OFS_TX_DATA:      next_rdata[15:0]  = tx_data;
      default:          next_rdata = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, stable at the answer edge
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (AVS_READ_IN & ~bus_ack) begin
      AVS_READDATA_OUT <= next_rdata;
    end
  end

  // software-written configuration registers
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      clk_cfg[DIR_RX] <= clk_cfg_t'(CFG_RESET);
      clk_cfg[DIR_TX] <= clk_cfg_t'(CFG_RESET);
      frm_cfg[DIR_RX] <= frm_cfg_t'(CFG_RESET);
      frm_cfg[DIR_TX] <= frm_cfg_t'(CFG_RESET);
      tx_sync_hold    <= WORD_RESET;
      tx_data         <= WORD_RESET;
      irq_enable      <= '0;
    end else if (wr_take) begin
      case (AVS_ADDRESS_IN)
        OFS_RX_CLK_MODE:  clk_cfg[DIR_RX] <= AVS_WRITEDATA_IN[16:0];
        OFS_RX_FRM_MODE:  frm_cfg[DIR_RX] <= AVS_WRITEDATA_IN[16:0];
        OFS_TX_CLK_MODE:  clk_cfg[DIR_TX] <= AVS_WRITEDATA_IN[16:0];
        OFS_TX_FRM_MODE:  frm_cfg[DIR_TX] <= AVS_WRITEDATA_IN[16:0];
        OFS_TX_SYNC_HOLD: tx_sync_hold    <= AVS_WRITEDATA_IN[15:0];
        OFS_IRQ_ENABLE:   irq_enable      <= AVS_WRITEDATA_IN[NUM_EVENTS-1:0];
        OFS_TX_DATA:      tx_data         <= AVS_WRITEDATA_IN[15:0];
        default:          ;
      endcase
    end
  end

  // per-direction bit clock, period counter and frame phase sequencer
  for (genvar d = 0; d < 2; d++) begin : g_dir
    logic [7:0] div_cnt;
    logic [8:0] per_cnt;
    logic       toggle;
    logic       next_frame;

    assign bit_tick[d]    = (div_cnt == clk_cfg[d].bit_div) & clk_lvl[d];
    // a frame begins at each bit tick that finds the period counter at zero, unless period is zero
    assign frame_start[d] = bit_tick[d] & (per_cnt == 9'h000) &
                            (clk_cfg[d].period != 8'h00);
    assign sync_end[d]    = bit_tick[d] & (phase[d] == PH_SYNC) &
                            (bit_cnt[d] == frm_cfg[d].sync_length);
    assign data_start[d]  = sync_end[d];

    // bit clock: two half bits of bit_div+1 reference cycles each
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        div_cnt    <= 8'h00;
        clk_lvl[d] <= 1'b0;
      end else if (div_cnt == clk_cfg[d].bit_div) begin
        div_cnt    <= 8'h00;
        clk_lvl[d] <= ~clk_lvl[d];
      end else begin
        div_cnt    <= div_cnt + 8'h01;
      end
    end

    // period counter over 2*(period+1) bit times
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        per_cnt <= 9'h000;
      end else if (bit_tick[d]) begin
        if (per_cnt >= {clk_cfg[d].period, 1'b1}) begin
          per_cnt <= 9'h000;
        end else begin
          per_cnt <= per_cnt + 9'h001;
        end
      end
    end

    // phase sequencer; a new frame start restarts a frame still running
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        phase[d]   <= PH_IDLE;
        bit_cnt[d] <= 8'h00;
      end else if (frame_start[d]) begin
        phase[d]   <= PH_SYNC;
        bit_cnt[d] <= 8'h00;
      end else if (bit_tick[d]) begin
        case (phase[d])
          PH_SYNC: begin
            if (sync_end[d]) begin
              phase[d]   <= PH_DATA;
              bit_cnt[d] <= 8'h00;
            end else begin
              bit_cnt[d] <= bit_cnt[d] + 8'h01;
            end
          end
          PH_DATA: begin
            if (bit_cnt[d] == {3'b000, frm_cfg[d].data_len}) begin
              phase[d] <= PH_IDLE;
            end
            bit_cnt[d] <= bit_cnt[d] + 8'h01;
          end
          default: begin
            phase[d]   <= PH_IDLE;
            bit_cnt[d] <= 8'h00;
          end
        endcase
      end
    end

    // frame pin waveform, registered so the pin never glitches
    always_comb begin
      case (frm_cfg[d].sync_out_select)
        SEL_NEG_PULSE: next_frame = ~(phase[d] == PH_SYNC);
        SEL_POS_PULSE: next_frame = (phase[d] == PH_SYNC);
        SEL_LOW_DATA:  next_frame = ~(phase[d] == PH_DATA);
        SEL_HIGH_DATA: next_frame = (phase[d] == PH_DATA);
        SEL_TOGGLE:    next_frame = toggle;
        default:       next_frame = 1'b0;
      endcase
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        frame_out[d] <= 1'b0;
        toggle       <= 1'b0;
      end else begin
        frame_out[d] <= next_frame;
        if (frame_start[d]) begin
          toggle <= ~toggle;
        end
      end
    end
  end

  // receive: sample the data pin while in sync, at most sixteen bits
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_shift     <= WORD_RESET;
      rx_sync_hold <= WORD_RESET;
    end else if (frame_start[DIR_RX]) begin
      // cleared at frame start so no bits of an older tag linger
      rx_shift <= WORD_RESET;
    end else if (bit_tick[DIR_RX] & (phase[DIR_RX] == PH_SYNC)) begin
      if (bit_cnt[DIR_RX] <= SYNC_BITS_LAST) begin
        rx_shift <= {rx_shift[14:0], RX_DATA_IN};
      end
      // tag reaches the holding register via the shifter
      if (sync_end[DIR_RX]) begin
        if (bit_cnt[DIR_RX] <= SYNC_BITS_LAST) begin
          rx_sync_hold <= {rx_shift[14:0], RX_DATA_IN};
        end else begin
          rx_sync_hold <= rx_shift;
        end
      end
    end
  end

  // transmit shifter: tag first, then normal data replaces it
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_shift <= WORD_RESET;
    end else if (data_start[DIR_TX]) begin
      tx_shift <= tx_data;
    end else if (frame_start[DIR_TX]) begin
      if (frm_cfg[DIR_TX].sync_data_enable) begin
        tx_shift <= tx_sync_hold;
      end else begin
        tx_shift <= WORD_RESET;
      end
    end else if (bit_tick[DIR_TX] & (phase[DIR_TX] != PH_IDLE)) begin
      if ((phase[DIR_TX] == PH_DATA) |
          (bit_cnt[DIR_TX] < SYNC_BITS_LAST)) begin
        tx_shift <= {tx_shift[14:0], 1'b0};
      end else begin
        tx_shift <= WORD_RESET;
      end
    end
  end

  // events; a set arriving with its clear is kept
  assign irq_events[ST_RX_SYNC]  = sync_end[DIR_RX];
  assign irq_events[ST_TX_SYNC]  = sync_end[DIR_TX] &
                                   frm_cfg[DIR_TX].sync_data_enable;
  assign irq_events[ST_RX_FRAME] = frame_start[DIR_RX];
  assign irq_events[ST_TX_FRAME] = frame_start[DIR_TX];

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_status <= '0;
    end else begin
      irq_status <= irq_events | (irq_status &
        ~(clr_take ? AVS_WRITEDATA_IN[NUM_EVENTS-1:0] : '0));
    end
  end

  // interrupt line; registered OR of the status bits that irq_enable lets through
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(irq_status & irq_enable);
    end
  end

  // pins: data one-way, clock and frame driven only when enabled
  assign TX_DATA_OUT         = (phase[DIR_TX] != PH_IDLE) & tx_shift[15];
  assign RX_CLOCK_PIN_OUT    = clk_lvl[DIR_RX];
  assign RX_CLOCK_PIN_OE_OUT = clk_cfg[DIR_RX].clk_out_en;
  assign TX_CLOCK_PIN_OUT    = clk_lvl[DIR_TX];
  assign TX_CLOCK_PIN_OE_OUT = clk_cfg[DIR_TX].clk_out_en;
  assign RX_FRAME_PIN_OUT    = frame_out[DIR_RX];
  assign RX_FRAME_PIN_OE_OUT = (frm_cfg[DIR_RX].sync_out_select
                                != SEL_INPUT);
  assign TX_FRAME_PIN_OUT    = frame_out[DIR_TX];
  assign TX_FRAME_PIN_OE_OUT = (frm_cfg[DIR_TX].sync_out_select
                                != SEL_INPUT);

endmodule

// >>> bench/frame_sync_props.sv
// checker: bus handshake, pin enables and interrupt mask timing
module frame_sync_props
  import frame_sync_pkg::*;
(
  input wire logic        REF_CLK_IN,          // clock
  input wire logic        RST_IN,              // async reset
  input wire logic [5:0]  AVS_ADDRESS_IN,      // address
  input wire logic        AVS_READ_IN,         // read
  input wire logic        AVS_WRITE_IN,        // write
  input wire logic [31:0] AVS_WRITEDATA_IN,    // write data
  input wire logic [31:0] AVS_READDATA_OUT,    // read data
  input wire logic        AVS_WAITREQUEST_OUT, // stall
  input wire logic        IRQ_OUT,             // interrupt
  input wire logic        RX_FRAME_PIN_OE_OUT, // rx frame enable
  input wire logic        TX_FRAME_PIN_OE_OUT, // tx frame enable
  input wire logic        TX_CLOCK_PIN_OE_OUT  // tx clock enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  // request and grant terms
  wire logic req = AVS_READ_IN | AVS_WRITE_IN;
  wire logic rd_ok = AVS_READ_IN & ~AVS_WAITREQUEST_OUT;
  wire logic wr_ok = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
  sequence stall_s;
    req && AVS_WAITREQUEST_OUT;
  endsequence
  sequence grant_s;
    req && !AVS_WAITREQUEST_OUT;
  endsequence
  // each request stalls exactly one cycle
  wait_once_a: assert property (stall_s |=> grant_s)
    else $error("stall longer than one cycle");
  wait_first_a: assert property (grant_s |-> $past(AVS_WAITREQUEST_OUT))
    else $error("grant without a stall cycle");
  idle_ready_a: assert property (!req |-> !AVS_WAITREQUEST_OUT)
    else $error("stall with no request");
  // the clear register and unmapped slots read as zero
  rd_zero_a: assert property (rd_ok && (AVS_ADDRESS_IN == OFS_IRQ_CLEAR ||
    AVS_ADDRESS_IN > OFS_TX_DATA) |-> AVS_READDATA_OUT == 32'h0)
    else $error("write-only or unmapped read not zero");
  upper_zero_a: assert property (rd_ok |-> AVS_READDATA_OUT[31:17] == 15'h0)
    else $error("upper read bits not zero");
  // pin enables only move after a register write
  rxf_oe_a: assert property (!$past(AVS_WRITE_IN) && !$past(AVS_WRITE_IN, 2)
    |-> $stable(RX_FRAME_PIN_OE_OUT)) else $error("rx frame oe moved");
  txf_oe_a: assert property (!$past(AVS_WRITE_IN) && !$past(AVS_WRITE_IN, 2)
    |-> $stable(TX_FRAME_PIN_OE_OUT)) else $error("tx frame oe moved");
  txk_oe_a: assert property (!$past(AVS_WRITE_IN) && !$past(AVS_WRITE_IN, 2)
    |-> $stable(TX_CLOCK_PIN_OE_OUT)) else $error("tx clock oe moved");
  // masking every source drops the line two cycles after the write
  irq_mask_a: assert property (wr_ok && AVS_ADDRESS_IN == OFS_IRQ_ENABLE &&
    AVS_WRITEDATA_IN[3:0] == 4'h0 |-> ##2 !IRQ_OUT [*3])
    else $error("irq high with all sources masked");
endmodule
bind sync_serial_frame_sync frame_sync_props frame_sync_props_inst (
  .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .IRQ_OUT(IRQ_OUT),
  .RX_FRAME_PIN_OE_OUT(RX_FRAME_PIN_OE_OUT),
  .TX_FRAME_PIN_OE_OUT(TX_FRAME_PIN_OE_OUT),
  .TX_CLOCK_PIN_OE_OUT(TX_CLOCK_PIN_OE_OUT));

// >>> bench/codec_model.sv
// codec partner: drives the rx tag line and captures the tx tag
module codec_model (
  input  wire logic   rx_clk, // rx bit clock level
  input  wire logic   rx_frm, // rx frame level
  input  wire logic   tx_clk, // tx bit clock level
  input  wire logic   tx_frm, // tx frame level
  input  wire logic   tx_dat, // tx data line
  output logic        rx_dat, // rx data line
  output logic [15:0] tx_tag  // last tag bits seen
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_dat = 1'b0;
    tx_tag = 16'h0000;
  end
  // ones inside the frame; outside, the line flips so stale bits show
  always @(posedge rx_clk or posedge rx_frm) begin
    rx_dat <= rx_frm ? 1'b1 : ~rx_dat;
  end
  // sample mid-bit on the rising clock while the frame is high
  always @(posedge tx_clk) begin
    if (tx_frm) begin
      tx_tag <= {tx_tag[14:0], tx_dat};
    end
  end
endmodule

// >>> bench/tb_sync_serial_frame_sync.sv
// testbench: registers, frame waveforms, sync tags and interrupt
module tb_sync_serial_frame_sync;
  import frame_sync_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 40000; // well above the longest frame waits
  logic        clk, rst, rd, wr, rxd, txd, irq, wt;
  logic        rk_o, rk_e, tk_o, tk_e, rf_o, rf_e, tf_o, tf_e;
  logic [5:0]  adr;
  logic [15:0] tag;
  logic [31:0] wd, rdo, rdat, seed;
  int          n_mismatch, tests_run, cyc;
  // pin levels: the codec never drives clock or frame pins
  wire logic   rk = rk_e ? rk_o : 1'b0;
  wire logic   tk = tk_e ? tk_o : 1'b0;
  wire logic   rf = rf_e ? rf_o : 1'b0;
  wire logic   tf = tf_e ? tf_o : 1'b0;
  sync_serial_frame_sync sync_serial_frame_sync_inst (
    .REF_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
    .AVS_READDATA_OUT(rdo), .AVS_WAITREQUEST_OUT(wt), .IRQ_OUT(irq),
    .RX_DATA_IN(rxd), .TX_DATA_OUT(txd), .RX_CLOCK_PIN_IN(rk),
    .RX_CLOCK_PIN_OUT(rk_o), .RX_CLOCK_PIN_OE_OUT(rk_e),
    .TX_CLOCK_PIN_IN(tk), .TX_CLOCK_PIN_OUT(tk_o),
    .TX_CLOCK_PIN_OE_OUT(tk_e), .RX_FRAME_PIN_IN(rf),
    .RX_FRAME_PIN_OUT(rf_o), .RX_FRAME_PIN_OE_OUT(rf_e),
    .TX_FRAME_PIN_IN(tf), .TX_FRAME_PIN_OUT(tf_o),
    .TX_FRAME_PIN_OE_OUT(tf_e));
  codec_model codec_model_inst (.rx_clk(rk), .rx_frm(rf), .tx_clk(tk),
    .tx_frm(tf), .tx_dat(txd), .rx_dat(rxd), .tx_tag(tag));
  // 20 MHz clock, running before any access as the system must ensure
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // xorshift source, fixed seed keeps runs repeatable
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // register words built from the package layouts
  function automatic logic [31:0] ck(logic oe, int per, int bd);
    return {15'h0, clk_cfg_t'{oe, 8'(per), 8'(bd)}};
  endfunction
  function automatic logic [31:0] fm(logic en, int s, int sl);
    return {15'h0, frm_cfg_t'{en, sync_sel_t'(3'(s)), 5'h3, 8'(sl)}};
  endfunction
  // expected level width in clocks; data phase is four bits here
  function automatic int exp_w(int s, int bd, int sl, int per);
    int c;
    c = 2 * (bd + 1);
    if (s <= 2) return (sl + 1) * c;
    if (s <= 4) return 4 * c;
    return 2 * (per + 1) * c;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    @(posedge clk);
    while (wt) @(posedge clk);
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic until_lvl(input logic p, input logic v);
    do @(negedge clk); while ((p ? tf_o : rf_o) !== v);
  endtask
  task automatic results();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      results();
    end
  end
  // main sequence
  initial begin
    int s, bd, sl, per, w;
    int lens[3];
    logic v;
    logic [15:0] h;
    logic [31:0] en;
    {rst, rd, wr, adr, wd, seed} = {1'b1, 2'b00, 6'h00, 32'h0, 32'h25};
    {n_mismatch, tests_run, cyc} = {32'd0, 32'd0, 32'd0};
    lens = '{3, 15, 19};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 40; a += 4) begin
      bus(1'b0, 6'(a), 32'h0);
      check(rdat, 32'h0);
    end
    bus(1'b1, 6'h28, 32'hFFFF_FFFF);
    bus(1'b1, OFS_IRQ_STATUS, 32'hF);
    bus(1'b1, OFS_TX_SYNC_HOLD, 32'hFFFF_FFFF);
    bus(1'b0, 6'h28, 32'h0);
    check(rdat, 32'h0);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    check(rdat, 32'h0);
    bus(1'b0, OFS_TX_SYNC_HOLD, 32'h0);
    check(rdat, 32'h0000_FFFF);
    for (int i = 0; i < 6; i++) begin
      s = (i < 5) ? i + 1 : 2;
      bd = (i < 5) ? int'(xs() % 3) : 0;
      sl = (i < 5) ? int'(xs() % 6) : 255;
      per = (i < 5) ? 7 : 255;
      bus(1'b1, OFS_TX_CLK_MODE, ck(1'b1, per, bd));
      bus(1'b1, OFS_TX_FRM_MODE, fm(1'b0, s, sl));
      check(tf_e, 32'h1);
      v = (s == 1 || s == 3) ? 1'b0 : 1'b1;
      until_lvl(1'b1, ~v);
      until_lvl(1'b1, v);
      until_lvl(1'b1, ~v);
      until_lvl(1'b1, v);
      w = 0;
      while (tf_o === v) begin
        w++;
        @(negedge clk);
      end
      check(w, exp_w(s, bd, sl, per));
    end
    bus(1'b1, OFS_TX_FRM_MODE, fm(1'b0, 0, 0));
    check(tf_e, 32'h0);
    bus(1'b1, OFS_RX_CLK_MODE, ck(1'b1, 15, 1));
    check(rk_e, 32'h1);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_RX_FRM_MODE, fm(1'b0, 2, lens[i]));
      repeat (2) begin
        until_lvl(1'b0, 1'b1);
        until_lvl(1'b0, 1'b0);
      end
      bus(1'b0, OFS_RX_SYNC_HOLD, 32'h0);
      check(rdat, lens[i] > 14 ? 32'h0000_FFFF :
        (32'h1 << (lens[i] + 1)) - 32'h1);
    end
    h = 16'(xs());
    bus(1'b1, OFS_TX_SYNC_HOLD, {16'h0, h});
    bus(1'b1, OFS_TX_CLK_MODE, ck(1'b1, 15, 1));
    for (int e = 1; e >= 0; e--) begin
      bus(1'b1, OFS_TX_FRM_MODE, fm(1'(e), 2, 15));
      repeat (2) begin
        until_lvl(1'b1, 1'b1);
        until_lvl(1'b1, 1'b0);
      end
      check({16'h0, tag}, e ? {16'h0, h} : 32'h0);
    end
    bus(1'b1, OFS_TX_CLK_MODE, ck(1'b0, 0, 1));
    check(tk_e, 32'h0);
    bus(1'b1, OFS_RX_CLK_MODE, ck(1'b1, 0, 1));
    repeat (100) @(negedge clk);
    bus(1'b1, OFS_IRQ_CLEAR, 32'hF);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    check(rdat, 32'h0);
    bus(1'b1, OFS_RX_CLK_MODE, ck(1'b1, 15, 1));
    until_lvl(1'b0, 1'b1);
    until_lvl(1'b0, 1'b0);
    bus(1'b1, OFS_RX_CLK_MODE, ck(1'b1, 0, 1));
    repeat (8) @(negedge clk);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    check(rdat, 32'h5);
    en = xs() & 32'hF;
    bus(1'b1, OFS_IRQ_ENABLE, en);
    repeat (2) @(negedge clk);
    check(irq, {31'h0, |(en[3:0] & 4'h5)});
    bus(1'b1, OFS_IRQ_ENABLE, 32'h4);
    repeat (2) @(negedge clk);
    check(irq, 32'h1);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h4);
    repeat (2) @(negedge clk);
    check(irq, 32'h0);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    check(rdat, 32'h1);
    results();
  end
endmodule
